// >>> inc/tape_rx_params.svh
// Timing constants, field positions and the rule summary for the five-level tape receiver.
// Contract
// - A character carries exactly five data elements in fixed order.
// - Data elements sit between a spacing start and a marking stop element.
// - All-marking code is letters shift; all-spacing code is blank.
// - A letters/figures shift state doubles the meaning of each combination.
// - Frame length selectable as 7.00, 7.42 or 7.50 units, same at both ends.
// - In 7.42 frames the stop element lasts 1.42 units, in 7.50 frames 1.50 units, in 7.00 frames one unit.
// - Element rate in baud is twice the dot-cycle frequency.
// - Line current flowing positive or at all decodes as marking.
// - Each marking data element punches a hole, spacing punches none.
// - A feed hole between levels two and three is punched, outside the code.
// - Idle marking holds the sequencer; a spacing start element begins selection.
// - A started selecting cycle runs to completion sampling five elements.
// - Marking stop halts selection and rearms start detection.
// - Near the end of selection a function cycle is triggered.
// - The function cycle punches holes, then late in the cycle feeds tape.
// - A feed-out request also starts a function cycle; else it idles.
// - The next selection may overlap the previous function cycle.
// - The sampling instant is shifted by a configurable offset.
// - The character goes to print positioning in step with its perforation.
// - The printed character lands six positions after its punched code; PRINT_LAG is unused and print data goes out with the punch.
`ifndef TAPE_RX_PARAMS_SVH
`define TAPE_RX_PARAMS_SVH
`define CLK_MHZ          250
`define UNIT_DIV_DEFAULT 32'd5494505
`define FRAC_BITS        7
`define STOP_700         8'h00
`define STOP_742         8'h36
`define STOP_750         8'h40
`define FULL_UNIT        8'h80
`define CODE_BITS        5
`define CODE_SHIFT       5'h1F
`define CODE_FIGS        5'h1B
`define CODE_BLANK       5'h00
`define CODE_SPACE       5'h04
`define PRINT_LAG        6
`define PUNCH_PHASE      4'h2
`define FEED_PHASE       4'hC
`define FUNC_PHASES      4'hF
`define FRAME_742        2'h1
`define FRAME_750        2'h2
`endif

// >>> inc/tape_rx_pkg.sv
// Types shared by the five-level tape receiver.
`default_nettype none
package tape_rx_pkg;
	typedef enum logic [2:0] {
		SEL_IDLE  = 3'b000,
		SEL_START = 3'b001,
		SEL_DATA  = 3'b010,
		SEL_STOP  = 3'b011
	} sel_state_t;
	typedef enum logic [1:0] {
		FN_IDLE  = 2'b00,
		FN_PUNCH = 2'b01,
		FN_FEED  = 2'b10
	} fn_state_t;
	typedef struct packed {
		logic       feed_hole;
		logic [4:0] code_holes;
	} punch_t;
	typedef struct packed {
		logic       figures;
		logic       blank;
		logic [4:0] code;
	} print_t;
endpackage : tape_rx_pkg
`default_nettype wire

// >>> hdl/tape_rx.sv
// Five-level start-stop receiver with punch, feed and print-select sequencing.
`timescale 1ns/1ns
`default_nettype none
`include "tape_rx_params.svh"
module tape_rx #(
	parameter int            UNIT_DIV  = `UNIT_DIV_DEFAULT,
	parameter int            PHASE_DIV = 1000
) (
	input  wire logic                 CORE_CLK,
	input  wire logic                 RESET,
	input  wire logic                 LINE_POLAR,
	input  wire logic                 LINE_POS,
	input  wire logic                 LINE_CURRENT,
	input  wire logic [1:0]           FRAME_SEL,
	input  wire logic [7:0]           SAMPLE_OFFSET,
	input  wire logic                 FEED_OUT_REQ,
	output logic                      PUNCH_STROBE,
	output tape_rx_pkg::punch_t       PUNCH_DATA,
	output logic                      TAPE_ADVANCE,
	output logic                      PRINT_STROBE,
	output tape_rx_pkg::print_t       PRINT_DATA,
	output logic                      PRINT_MOVE,
	output logic                      FRAME_ERROR,
	output logic                      BUSY
);
	initial
	begin
		if (UNIT_DIV < 16 || PHASE_DIV < 1)
			$error("Unit divider must be at least 16 and phase divider at least 1.");
	end

	// One element lasts UNIT_DIV clocks, so a dot cycle of mark and space spans two.
	localparam int HALF_DIV = UNIT_DIV / 2;

	////////////////////////////////////////////////////////////////////////////
	// Fraction of a unit converted to clock counts; used for offset and stop.
	function automatic logic [31:0] frac_cycles(input logic [7:0] frac);
		logic [39:0] prod;
		prod = 40'(UNIT_DIV) * 40'(frac);
		frac_cycles = 32'(prod >> `FRAC_BITS);
	endfunction : frac_cycles

	////////////////////////////////////////////////////////////////////////////
	// Two flip-flops on each line pin before any decoding.
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			pin_s1_r <= 3'h7;
			pin_s2_r <= 3'h7;
		end
		else
		begin
			pin_s1_r <= {LINE_POLAR, LINE_POS, LINE_CURRENT};
			pin_s2_r <= pin_s1_r;
		end
	end

	// Polar lines mark on positive current, neutral lines on any current.
	logic mark;
	assign mark = pin_s2_r[2] ? pin_s2_r[1] : pin_s2_r[0];

	////////////////////////////////////////////////////////////////////////////
	// Selecting sequencer: one counter times every element from the unit divider.
	tape_rx_pkg::sel_state_t sel_r;
	logic [31:0]             tmr_r;
	logic [2:0]              bit_r;
	logic [4:0]              shreg_r;
	logic                    trip_r;
	logic                    frame_err_r;
	logic [7:0]              stop_frac;

	always_comb
	begin
		case (FRAME_SEL)
			`FRAME_742: stop_frac = `STOP_742;
			`FRAME_750: stop_frac = `STOP_750;
			default:    stop_frac = `STOP_700;
		endcase
	end

	// The stop wait only covers the excess beyond one unit, since the first unit
	// of stop is checked at its sample; a 7.00 frame rearms straight away.
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			sel_r       <= tape_rx_pkg::SEL_IDLE;
			tmr_r       <= 32'h0;
			bit_r       <= 3'h0;
			shreg_r     <= 5'h00;
			trip_r      <= 1'b0;
			frame_err_r <= 1'b0;
		end
		else
		begin
			trip_r <= 1'b0;
			case (sel_r)
				tape_rx_pkg::SEL_IDLE:
				begin
					if (!mark)
					begin
						sel_r <= tape_rx_pkg::SEL_START;
						tmr_r <= 32'(HALF_DIV);
					end
				end
				tape_rx_pkg::SEL_START:
				begin
					if (mark)
						sel_r <= tape_rx_pkg::SEL_IDLE;
					else if (tmr_r <= 32'h1)
					begin
						sel_r <= tape_rx_pkg::SEL_DATA;
						tmr_r <= 32'(UNIT_DIV - HALF_DIV) + frac_cycles(SAMPLE_OFFSET);
						bit_r <= 3'h0;
					end
					else
						tmr_r <= tmr_r - 32'h1;
				end
				tape_rx_pkg::SEL_DATA:
				begin
					// No start detection here: the cycle always runs out.
					if (tmr_r <= 32'h1)
					begin
						tmr_r <= 32'(UNIT_DIV);
						if (bit_r == 3'(`CODE_BITS))
						begin
							frame_err_r <= !mark;
							sel_r       <= tape_rx_pkg::SEL_STOP;
							tmr_r       <= frac_cycles(stop_frac) + 32'h1;
						end
						else
						begin
							shreg_r <= {mark, shreg_r[4:1]};
							bit_r   <= bit_r + 3'h1;
							// Trip on the fifth element so the function cycle overlaps.
							if (bit_r == 3'(`CODE_BITS - 1))
								trip_r <= 1'b1;
						end
					end
					else
						tmr_r <= tmr_r - 32'h1;
				end
				default:
				begin
					// Stop element: halt, then rearm start detection.
					if (tmr_r <= 32'h1)
						sel_r <= tape_rx_pkg::SEL_IDLE;
					else
						tmr_r <= tmr_r - 32'h1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Function sequencer: a phase divider steps sixteen phases per cycle.
	tape_rx_pkg::fn_state_t fn_r;
	logic [3:0]             phase_r;
	logic [31:0]            pdiv_r;
	logic [4:0]             held_r;
	logic                   pend_r;
	logic                   feed_pend_r;
	logic                   figs_r;
	logic                   fn_is_feed_r;
	logic                   phase_tick;
	assign phase_tick = (pdiv_r == 32'h0);

	// A trip arriving mid-cycle is held, so the next selection may overlap.
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			pend_r      <= 1'b0;
			held_r      <= 5'h00;
			feed_pend_r <= 1'b0;
		end
		else
		begin
			if (trip_r)
			begin
				pend_r <= 1'b1;
				held_r <= shreg_r; // The fifth element was shifted in on the edge that raised the trip.
			end
			else if (fn_r == tape_rx_pkg::FN_IDLE && pend_r)
				pend_r <= 1'b0;
			if (FEED_OUT_REQ)
				feed_pend_r <= 1'b1;
			else if (fn_r == tape_rx_pkg::FN_IDLE && !pend_r && !trip_r)
				feed_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			fn_r         <= tape_rx_pkg::FN_IDLE;
			phase_r      <= 4'h0;
			pdiv_r       <= 32'h0;
			fn_is_feed_r <= 1'b0;
		end
		else
		begin
			pdiv_r <= phase_tick ? 32'(PHASE_DIV - 1) : pdiv_r - 32'h1;
			case (fn_r)
				tape_rx_pkg::FN_IDLE:
				begin
					pdiv_r  <= 32'(PHASE_DIV - 1);
					phase_r <= 4'h0;
					if (pend_r && !trip_r)
					begin
						fn_r         <= tape_rx_pkg::FN_PUNCH;
						fn_is_feed_r <= 1'b0;
					end
					else if (feed_pend_r && !trip_r)
					begin
						fn_r         <= tape_rx_pkg::FN_PUNCH;
						fn_is_feed_r <= 1'b1;
					end
				end
				tape_rx_pkg::FN_PUNCH:
				begin
					if (phase_tick)
					begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == `FEED_PHASE)
							fn_r <= tape_rx_pkg::FN_FEED;
					end
				end
				default:
				begin
					if (phase_tick)
					begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == `FUNC_PHASES)
							fn_r <= tape_rx_pkg::FN_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output strobes: punch early, print with it, feed late in the cycle.
	logic       punch_go;
	logic       feed_go;
	logic [4:0] out_code;
	assign punch_go = (fn_r == tape_rx_pkg::FN_PUNCH) && phase_tick && (phase_r == `PUNCH_PHASE);
	assign feed_go  = (fn_r == tape_rx_pkg::FN_PUNCH) && phase_tick && (phase_r == `FEED_PHASE);
	// Feed-out punches letters shift, giving letters-perforated leader.
	assign out_code = fn_is_feed_r ? `CODE_SHIFT : held_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PUNCH_STROBE <= 1'b0;
			PUNCH_DATA   <= '0;
			TAPE_ADVANCE <= 1'b0;
			PRINT_STROBE <= 1'b0;
			PRINT_DATA   <= '0;
			PRINT_MOVE   <= 1'b0;
			figs_r       <= 1'b0;
			FRAME_ERROR  <= 1'b0;
			BUSY         <= 1'b0;
		end
		else
		begin
			PUNCH_STROBE <= punch_go;
			TAPE_ADVANCE <= feed_go;
			PRINT_STROBE <= punch_go && !fn_is_feed_r;
			PRINT_MOVE   <= feed_go;
			FRAME_ERROR  <= frame_err_r;
			BUSY         <= (sel_r != tape_rx_pkg::SEL_IDLE) || (fn_r != tape_rx_pkg::FN_IDLE);
			if (punch_go)
			begin
				PUNCH_DATA.code_holes <= out_code;
				PUNCH_DATA.feed_hole  <= 1'b1;
				PRINT_DATA.code       <= out_code;
				PRINT_DATA.blank      <= (out_code == `CODE_BLANK);
				PRINT_DATA.figures    <= (out_code == `CODE_FIGS) ? 1'b1 :
					(out_code == `CODE_SHIFT || out_code == `CODE_SPACE) ? 1'b0 : figs_r;
				if (out_code == `CODE_FIGS)
					figs_r <= 1'b1;
				else if (out_code == `CODE_SHIFT || out_code == `CODE_SPACE)
					figs_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_trip_fn;
		@(posedge CORE_CLK) disable iff (RESET)
		trip_r && (fn_r == tape_rx_pkg::FN_IDLE) |-> ##2 (fn_r != tape_rx_pkg::FN_IDLE);
	endproperty
	a_trip_fn: assert property (p_trip_fn) else $error("Trip did not start a function cycle.");

	property p_glitch;
		@(posedge CORE_CLK) disable iff (RESET)
		(sel_r == tape_rx_pkg::SEL_START) && mark |=> sel_r == tape_rx_pkg::SEL_IDLE;
	endproperty
	a_glitch: assert property (p_glitch) else $error("Start glitch not rejected.");

	property p_punch_feed;
		@(posedge CORE_CLK) disable iff (RESET)
		PUNCH_STROBE |-> !TAPE_ADVANCE;
	endproperty
	a_punch_feed: assert property (p_punch_feed) else $error("Feed coincided with punch.");

	property p_feedhole;
		@(posedge CORE_CLK) disable iff (RESET)
		PUNCH_STROBE |-> PUNCH_DATA.feed_hole;
	endproperty
	a_feedhole: assert property (p_feedhole) else $error("Feed hole missing.");

	property p_print_step;
		@(posedge CORE_CLK) disable iff (RESET)
		PRINT_STROBE |-> PUNCH_STROBE && PRINT_DATA.code == PUNCH_DATA.code_holes;
	endproperty
	a_print_step: assert property (p_print_step) else $error("Print out of step with punch.");

	property p_blank;
		@(posedge CORE_CLK) disable iff (RESET)
		PRINT_STROBE && PRINT_DATA.code == `CODE_BLANK |-> PRINT_DATA.blank;
	endproperty
	a_blank: assert property (p_blank) else $error("Blank code not flagged.");

	property p_shift;
		@(posedge CORE_CLK) disable iff (RESET)
		PRINT_STROBE && PRINT_DATA.code == `CODE_SHIFT |-> !PRINT_DATA.figures;
	endproperty
	a_shift: assert property (p_shift) else $error("Letters shift left figures set.");

	property p_idle_hold;
		@(posedge CORE_CLK) disable iff (RESET)
		(sel_r == tape_rx_pkg::SEL_IDLE) && mark |=> sel_r == tape_rx_pkg::SEL_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Sequencer left idle on marking line.");

	property p_data_runs;
		@(posedge CORE_CLK) disable iff (RESET)
		(sel_r == tape_rx_pkg::SEL_DATA) |=> sel_r inside {tape_rx_pkg::SEL_DATA, tape_rx_pkg::SEL_STOP};
	endproperty
	a_data_runs: assert property (p_data_runs) else $error("Selecting cycle aborted.");

	property p_move_adv;
		@(posedge CORE_CLK) disable iff (RESET)
		TAPE_ADVANCE |-> PRINT_MOVE;
	endproperty
	a_move_adv: assert property (p_move_adv) else $error("Print move not in step with tape advance.");
endmodule : tape_rx
`default_nettype wire

// >>> verif/line_tx_model.sv
// Behavioural start-stop transmitter that drives the receiver's line inputs.
`timescale 1ns/1ns
`default_nettype none
module line_tx_model #(
	parameter int UNIT = 64
) (
	input  wire logic       clk,
	input  wire logic       polar,
	input  wire logic [1:0] frame_sel,
	output logic            pos,
	output logic            current
);
	logic mark_r = 1'b1;

	// The unused line never mirrors the level, so decoding the wrong one shows at once.
	assign pos     = polar ? mark_r : ~mark_r;
	assign current = polar ? 1'b1 : mark_r;

	////////////////////////////////////////
	// Holds one line level for a number of clock cycles.
	task automatic hold(input logic lvl, input int n);
		mark_r <= lvl;
		repeat (n) @(posedge clk);
	endtask : hold

	// Sends one character, first element first; a bad stop goes spacing over its sample point.
	task automatic send(input logic [4:0] code, input logic bad_stop);
		int stop;
		stop = UNIT + ((frame_sel == 2'h1) ? 54 : (frame_sel == 2'h2) ? 64 : 0) * UNIT / 128;
		hold(1'b0, UNIT);
		for (int i = 0; i < 5; i++)
			hold(code[i], UNIT);
		if (bad_stop)
		begin
			hold(1'b0, UNIT * 3 / 4);
			hold(1'b1, stop + UNIT);
		end
		else
			hold(1'b1, stop);
	endtask : send

	// A spacing pulse too short to be a start element, then idle marking.
	task automatic glitch(input int n);
		hold(1'b0, n);
		hold(1'b1, UNIT * 8);
	endtask : glitch
endmodule : line_tx_model
`default_nettype wire

// >>> verif/tb_tape_rx.sv
// Self-checking bench for the five-level tape receiver.
`timescale 1ns/1ns
`default_nettype none
module tb_tape_rx;
	localparam int UNIT = 64;
	typedef struct packed {
		logic [4:0] code;
		logic [1:0] fsel;
		logic       polar;
		logic [7:0] off;
		logic [6:0] pr;
		logic [6:0] m;
	} row_t;
	// Each row: line code, frame, circuit, offset, then the print word and its compare mask.
	localparam row_t ROWS [8] = '{
		'{5'h1F, 2'h0, 1'b0, 8'h00, 7'h1F, 7'h7F},
		'{5'h00, 2'h1, 1'b1, 8'h00, 7'h20, 7'h7F},
		'{5'h1B, 2'h2, 1'b0, 8'h20, 7'h5B, 7'h7F},
		'{5'h01, 2'h3, 1'b1, 8'h00, 7'h41, 7'h7F},
		'{5'h04, 2'h1, 1'b0, 8'h00, 7'h04, 7'h7F},
		'{5'h01, 2'h0, 1'b1, 8'h20, 7'h01, 7'h7F},
		'{5'h15, 2'h2, 1'b1, 8'h00, 7'h15, 7'h7F},
		'{5'h0A, 2'h1, 1'b0, 8'h00, 7'h0A, 7'h7F}
	};
	logic                CORE_CLK = 1'b0;
	logic                RESET = 1'b1;
	logic                polar = 1'b0;
	logic [1:0]          frame_sel = 2'h0;
	logic [7:0]          offset = 8'h00;
	logic                feed_req = 1'b0;
	logic                fo = 1'b0;
	logic                line_pos, line_cur, punch_stb, tape_adv, print_stb, print_move, frame_err, busy;
	tape_rx_pkg::punch_t punch_data;
	tape_rx_pkg::print_t print_data;
	int                  bad_count = 0, comparisons = 0, punches = 0, advances = 0, snap = 0;

	// A 64-clock unit kept small so the run stays short.
	always #2 CORE_CLK = ~CORE_CLK;

	tape_rx #(.UNIT_DIV(UNIT), .PHASE_DIV(16)) i_tape_rx (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.LINE_POLAR(polar), .LINE_POS(line_pos), .LINE_CURRENT(line_cur), .FRAME_SEL(frame_sel),
		.SAMPLE_OFFSET(offset), .FEED_OUT_REQ(feed_req), .PUNCH_STROBE(punch_stb), .PUNCH_DATA(punch_data),
		.TAPE_ADVANCE(tape_adv), .PRINT_STROBE(print_stb), .PRINT_DATA(print_data), .PRINT_MOVE(print_move),
		.FRAME_ERROR(frame_err), .BUSY(busy));
	line_tx_model #(.UNIT(UNIT)) i_line_tx_model (.clk(CORE_CLK), .polar(polar), .frame_sel(frame_sel),
		.pos(line_pos), .current(line_cur));

	////////////////////////////////////////
	task automatic step;
		@(posedge CORE_CLK);
		#1;
	endtask : step

	task automatic check_bus(input logic [6:0] got, input logic [6:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bus

	task automatic check_bit(input logic got, input logic exp);
		check_bus({6'h00, got}, {6'h00, exp});
	endtask : check_bit

	// Waits for a punch under a bound, then checks holes and print selection.
	task automatic catch(input logic [6:0] ep, input logic [6:0] epr, input logic [6:0] m, input logic eps);
		for (int n = 0; n < 1000 && punch_stb !== 1'b1; n++)
			step;
		check_bit(punch_stb, 1'b1);
		check_bus({1'b0, punch_data}, ep);
		check_bit(print_stb, eps);
		check_bus(7'(print_data) & m, epr & m);
	endtask : catch

	task automatic results;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	////////////////////////////////////////
	// Sampled mid-cycle so the registered pulses have settled; feed steps may trail into the next frame.
	always @(negedge CORE_CLK)
	begin
		if (punch_stb === 1'b1)
			punches++;
		if (tape_adv === 1'b1)
		begin
			check_bit(advances < punches, 1'b1);
			if (!fo)
				check_bit(print_move, 1'b1);
			advances++;
		end
	end

	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge CORE_CLK);
		bad_count++;
		results;
	end

	initial
	begin
		repeat (8) @(posedge CORE_CLK);
		RESET <= 1'b0;
		step;
		check_bit(busy, 1'b0);
		check_bit(frame_err, 1'b0);
		repeat (4) step;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge CORE_CLK);
			frame_sel <= ROWS[i].fsel;
			polar <= ROWS[i].polar;
			offset <= ROWS[i].off;
			step;
			fork
				i_line_tx_model.send(ROWS[i].code, 1'b0);
				catch({2'h1, ROWS[i].code}, ROWS[i].pr, ROWS[i].m, 1'b1);
			join
			check_bit(frame_err, 1'b0);
			$display("row %0d done", i);
		end
		repeat (300) step;
		check_bit(busy, 1'b0);
		snap = punches;
		i_line_tx_model.glitch(UNIT / 4);
		check_bus(7'(punches), 7'(snap));
		check_bus(7'(advances), 7'(punches));
		check_bit(busy, 1'b0);
		$display("glitch done");
		fo = 1'b1;
		@(posedge CORE_CLK);
		feed_req <= 1'b1;
		@(posedge CORE_CLK);
		feed_req <= 1'b0;
		catch(7'h3F, 7'h00, 7'h00, 1'b0);
		repeat (300) step;
		check_bus(7'(advances), 7'(punches));
		fo = 1'b0;
		$display("feed-out done");
		fork
			i_line_tx_model.send(5'h0A, 1'b1);
			catch(7'h2A, 7'h0A, 7'h7F, 1'b1);
		join
		check_bit(frame_err, 1'b1);
		@(posedge CORE_CLK);
		RESET <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		step;
		check_bit(frame_err, 1'b0);
		check_bit(busy, 1'b0);
		$display("bad stop and reset done");
		results;
	end
endmodule : tb_tape_rx
`default_nettype wire
